// [core/prwc_defines.svh]
/*
 Offsets, field positions, reset values and timing counts for the power reduction
 and wake-up controller. Assumes a 125 MHz system clock.
*/
`ifndef PRWC_DEFINES_SVH
`define PRWC_DEFINES_SVH

`define PRWC_ADDR_PWR_CTRL     8'h87
`define PRWC_ADDR_PERIPH_PWR   8'hB5
`define PRWC_ADDR_WAKE_CFG     8'hB6
`define PRWC_ADDR_STATUS       8'hB7
`define PRWC_PWR_CTRL_RESET    8'h00
`define PRWC_PERIPH_PWR_RESET  8'h00
`define PRWC_WAKE_CFG_RESET    8'h00
`define PRWC_PWR_CTRL_WMASK    8'hDF
`define PRWC_PERIPH_PWR_WMASK  8'hEF
`define PRWC_BIT_BOI           4
`define PRWC_BIT_COMP_PD       5
`define PRWC_BIT_RTC_PD        7
`define PRWC_CLK_NS            8
`define PRWC_XTAL_CYCLES       1024
`define PRWC_EXT_CYCLES        32
`define PRWC_RC_MIN_MS         200
`define PRWC_RC_MAX_MS         300
`define PRWC_RC_MIN_CYCLES     ((`PRWC_RC_MIN_MS * 1000000 + `PRWC_CLK_NS - 1) / `PRWC_CLK_NS)

`endif

// [core/prwc_pkg.sv]
/*
 Types shared by the power reduction and wake-up controller.
 Assumes the defines header is compiled alongside.
*/
package prwc_pkg;

  typedef enum logic [1:0] {
    PRWC_MODE_NORMAL = 2'h0,
    PRWC_MODE_IDLE   = 2'h1,
    PRWC_MODE_PD     = 2'h2,
    PRWC_MODE_TPD    = 2'h3
  } prwc_mode_t;

  typedef enum logic [1:0] {
    PRWC_SRC_XTAL = 2'h0,
    PRWC_SRC_RC   = 2'h1,
    PRWC_SRC_EXT  = 2'h2
  } prwc_clk_src_t;

  typedef struct packed {
    logic ext0;
    logic ext1;
    logic brownout;
    logic keyboard;
    logic rtc;
    logic watchdog;
    logic comparator;
  } prwc_irq_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } prwc_bus_req_t;

  typedef struct packed {
    logic osc_run;
    logic rc_osc_run;
    logic bod_run;
    logic comp_run;
    logic rtc_run;
    logic wdt_run;
    logic cpu_run;
  } prwc_power_t;

endpackage

// [core/prwc_stab_timer.sv]
/*
 Oscillator stability timer: counts qualified ticks after a restart and flags done.
 Assumes start is a one-cycle pulse and tick a one-cycle enable on clk.
*/
module prwc_stab_timer #(
  parameter int WIDTH = 26
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             srst,
  // Control
  input  wire logic             start,
  input  wire logic             tick,
  input  wire logic [WIDTH-1:0] target,
  // Status
  output logic                  done
);
  typedef struct packed {
    logic [WIDTH-1:0] cnt;
    logic             busy;
    logic             done;
  } prwc_timer_state_t;

  prwc_timer_state_t st_reg;
  prwc_timer_state_t st_next;

  always_comb begin
    st_next      = st_reg;
    st_next.done = 1'b0;
    if (start) begin
      st_next.cnt  = '0;
      st_next.busy = 1'b1;
    end else if (st_reg.busy && tick) begin
      if (st_reg.cnt + WIDTH'(1) >= target) begin
        st_next.busy = 1'b0;
        st_next.done = 1'b1;
      end else begin
        st_next.cnt = st_reg.cnt + WIDTH'(1);
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign done = st_reg.done;
endmodule // prwc_stab_timer

// [core/prwc_ctrl.sv]
/*
 Power reduction and wake-up controller: power control registers, mode decode,
 oscillator and analog block gating, wake qualification and stability wait.
 Assumes wake and reset request inputs are synchronous to clk; the external
 clock input is a pin and is synchronised here.
*/
// The strobed register port is this design's own decision.
`include "prwc_defines.svh"
// How it works
// - Two mode bits select normal, idle, power-down, total.
// - Power-down halts main oscillator and system clock.
// - Any reset or listed interrupt exits power-down.
// - Reset wakes only if that reset enabled.
// - Interrupt wakes only if enabled and global enable.
// - RC oscillator off unless system clock with RTC.
// - Wake restarts oscillator, holds execution until stable.
// - Crystal: stable after 1024 processor clocks.
// - Internal RC: wait 200 to 300 ms.
// - External clock: stable after 32 oscillator cycles.
// - Brownout and selected watchdog keep running in power-down.
// - Comparators run unless disabled and powered down.
// - RTC runs in power-down unless its power-down bit.
// - Total power-down: no brownout reset, interrupt, comparator wake.
// - Total power-down wake only watchdog, external, keyboard, RTC.
// - Register layout bits 7..0, all reset to zero.
// - Brownout interrupt only if enable bit set, else reset.
module prwc_ctrl
  import prwc_pkg::*;
#(
  parameter int RC_WAIT_CYCLES = `PRWC_RC_MIN_CYCLES,
  parameter int XTAL_CYCLES    = `PRWC_XTAL_CYCLES,
  parameter int EXT_CYCLES     = `PRWC_EXT_CYCLES
) (
  // Clock and reset
  clk,
  srst,
  // Register port
  bus,
  rdata,
  // Clock configuration
  clk_src,
  ext_clk_pin,
  // Enables held by the processor core
  global_irq_enable,
  irq_enable,
  watchdog_clock_select,
  comp_enabled,
  // Events
  irq_req,
  reset_req,
  reset_enable,
  brownout_cond,
  // Outputs
  power,
  mode,
  brownout_irq,
  brownout_reset,
  wake_reset,
  double_baud_select,
  framing_error_select
);
  import prwc_pkg::*;

  input  wire logic          clk;
  input  wire logic          srst;
  input  wire prwc_bus_req_t bus;
  output logic [7:0]         rdata;
  input  wire prwc_clk_src_t clk_src;
  input  wire logic          ext_clk_pin;
  input  wire logic          global_irq_enable;
  input  wire prwc_irq_t     irq_enable;
  input  wire logic          watchdog_clock_select;
  input  wire logic          comp_enabled;
  input  wire prwc_irq_t     irq_req;
  input  wire logic          reset_req;
  input  wire logic          reset_enable;
  input  wire logic          brownout_cond;
  output prwc_power_t        power;
  output prwc_mode_t         mode;
  output logic               brownout_irq;
  output logic               brownout_reset;
  output logic               wake_reset;
  output logic               double_baud_select;
  output logic               framing_error_select;

  localparam int TW = 26;

  typedef enum logic [1:0] {
    PRWC_ST_RUN,
    PRWC_ST_SLEEP,
    PRWC_ST_WAIT
  } prwc_state_t;

  typedef struct packed {
    prwc_state_t   st;
    logic [7:0]    power_control;
    logic [7:0]    peripheral_power_control;
    logic [7:0]    rdata;
    logic          tpd_entered;
    logic          wake_by_reset;
    logic [2:0]    ext_sync;
    prwc_power_t   power;
    logic          bo_irq;
    logic          bo_rst;
    logic          wake_rst;
    logic          start;
  } prwc_ctrl_state_t;

  prwc_ctrl_state_t s_reg;
  prwc_ctrl_state_t s_next;

  logic          stab_done;
  logic          tick;
  logic [TW-1:0] target;
  prwc_mode_t    cur_mode;
  logic          in_pd;
  logic          in_tpd;
  prwc_irq_t     wake_ok;
  logic          irq_wake;
  logic          rst_wake;
  logic          rtc_enabled;
  logic          comp_off;
  logic          tpd_active;

  assign cur_mode = prwc_mode_t'(s_reg.power_control[1:0]);
  assign in_pd    = s_reg.st != PRWC_ST_RUN;
  assign in_tpd   = s_reg.tpd_entered;
  assign rtc_enabled = !s_reg.peripheral_power_control[`PRWC_BIT_RTC_PD];
  assign comp_off = !comp_enabled && s_reg.peripheral_power_control[`PRWC_BIT_COMP_PD];
  assign tpd_active = in_tpd || cur_mode == PRWC_MODE_TPD;

  always_comb begin
    wake_ok = irq_req & irq_enable & {7{global_irq_enable}};
    if (in_tpd) begin
      wake_ok.brownout   = 1'b0;
      wake_ok.comparator = 1'b0;
      wake_ok.watchdog   = wake_ok.watchdog && watchdog_clock_select;
    end
  end
  assign irq_wake = |wake_ok;
  assign rst_wake = reset_req && reset_enable && (!in_tpd || watchdog_clock_select);

  // Stability tick: external clock counts its own rising edges, others count clk
  assign tick = (clk_src == PRWC_SRC_EXT) ? (s_reg.ext_sync[1] && !s_reg.ext_sync[2])
                                          : 1'b1;
  always_comb begin
    unique case (clk_src)
      PRWC_SRC_XTAL: target = TW'(XTAL_CYCLES);
      PRWC_SRC_RC:   target = TW'(RC_WAIT_CYCLES);
      PRWC_SRC_EXT:  target = TW'(EXT_CYCLES);
      default:       target = TW'(XTAL_CYCLES);
    endcase
  end

  always_comb begin
    s_next          = s_reg;
    s_next.start    = 1'b0;
    s_next.wake_rst = 1'b0;
    s_next.ext_sync = {s_reg.ext_sync[1:0], ext_clk_pin};
    s_next.rdata    = 8'h00;

    if (bus.wr) begin
      unique case (bus.addr)
        `PRWC_ADDR_PWR_CTRL:
          s_next.power_control = bus.wdata & `PRWC_PWR_CTRL_WMASK;
        `PRWC_ADDR_PERIPH_PWR:
          s_next.peripheral_power_control = bus.wdata & `PRWC_PERIPH_PWR_WMASK;
        default: ;
      endcase
    end
    if (bus.rd) begin
      unique case (bus.addr)
        `PRWC_ADDR_PWR_CTRL:   s_next.rdata = s_reg.power_control;
        `PRWC_ADDR_PERIPH_PWR: s_next.rdata = s_reg.peripheral_power_control;
        `PRWC_ADDR_STATUS:     s_next.rdata = {4'h0, s_reg.wake_by_reset, in_tpd,
                                               s_reg.st == PRWC_ST_WAIT, in_pd};
        default:               s_next.rdata = 8'h00;
      endcase
    end

    unique case (s_reg.st)
      PRWC_ST_RUN: begin
        if (cur_mode == PRWC_MODE_PD || cur_mode == PRWC_MODE_TPD) begin
          s_next.st          = PRWC_ST_SLEEP;
          s_next.tpd_entered = cur_mode == PRWC_MODE_TPD;
        end
      end
      PRWC_ST_SLEEP: begin
        if (rst_wake || irq_wake) begin
          s_next.st            = PRWC_ST_WAIT;
          s_next.start         = 1'b1;
          s_next.wake_by_reset = rst_wake;
        end
      end
      PRWC_ST_WAIT: begin
        if (stab_done) begin
          s_next.st            = PRWC_ST_RUN;
          s_next.tpd_entered   = 1'b0;
          s_next.wake_rst      = s_reg.wake_by_reset;
          s_next.power_control = {s_reg.power_control[7:2], 2'b00};
          if (s_reg.wake_by_reset) begin
            s_next.power_control            = `PRWC_PWR_CTRL_RESET;
            s_next.peripheral_power_control = `PRWC_PERIPH_PWR_RESET;
          end
        end
      end
    endcase

    // Power gating outputs
    s_next.power.osc_run    = s_next.st != PRWC_ST_SLEEP;
    s_next.power.rc_osc_run = (s_next.st != PRWC_ST_SLEEP)
                              || (clk_src == PRWC_SRC_RC && rtc_enabled);
    s_next.power.bod_run    = !(s_next.st != PRWC_ST_RUN && s_next.tpd_entered);
    s_next.power.comp_run   = !comp_off && s_next.power.bod_run;
    s_next.power.rtc_run    = rtc_enabled;
    s_next.power.wdt_run    = (s_next.st != PRWC_ST_SLEEP) || watchdog_clock_select;
    s_next.power.cpu_run    = s_next.st == PRWC_ST_RUN;

    // Brownout routing
    s_next.bo_irq = brownout_cond && !tpd_active
                    && s_reg.power_control[`PRWC_BIT_BOI];
    s_next.bo_rst = brownout_cond && !tpd_active
                    && !s_reg.power_control[`PRWC_BIT_BOI];
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      s_reg.st                       <= PRWC_ST_RUN;
      s_reg.power_control            <= `PRWC_PWR_CTRL_RESET;
      s_reg.peripheral_power_control <= `PRWC_PERIPH_PWR_RESET;
      s_reg.rdata                    <= 8'h00;
      s_reg.tpd_entered              <= 1'b0;
      s_reg.wake_by_reset            <= 1'b0;
      s_reg.ext_sync                 <= 3'h0;
      s_reg.power                    <= '1;
      s_reg.bo_irq                   <= 1'b0;
      s_reg.bo_rst                   <= 1'b0;
      s_reg.wake_rst                 <= 1'b0;
      s_reg.start                    <= 1'b0;
    end else begin
      s_reg <= s_next;
    end
  end

  prwc_stab_timer #(
    .WIDTH (TW)
  ) u_stab (
    .clk    (clk),
    .srst   (srst),
    .start  (s_reg.start),
    .tick   (tick),
    .target (target),
    .done   (stab_done)
  );

  assign rdata                = s_reg.rdata;
  assign power                = s_reg.power;
  assign mode                 = cur_mode;
  assign brownout_irq         = s_reg.bo_irq;
  assign brownout_reset       = s_reg.bo_rst;
  assign wake_reset           = s_reg.wake_rst;
  assign double_baud_select   = s_reg.power_control[7];
  assign framing_error_select = s_reg.power_control[6];
endmodule // prwc_ctrl

// [verification/prwc_ctrl_monitor.sv]
/*
 Checker on the ports of prwc_ctrl: sleep entry, wake gating, stability waits.
 Bound from the bench top; one clock, srst synchronous active high.
*/
module prwc_ctrl_monitor #(
  parameter int RC_WAIT_CYCLES = 20,
  parameter int XTAL_CYCLES    = 1024,
  parameter int EXT_CYCLES     = 32
) (
  // Clock and reset
  input wire logic                    clk,
  input wire logic                    srst,
  // Block inputs
  input wire prwc_pkg::prwc_bus_req_t bus,
  input wire prwc_pkg::prwc_clk_src_t clk_src,
  input wire logic                    ext_clk_pin,
  input wire logic                    global_irq_enable,
  input wire prwc_pkg::prwc_irq_t     irq_enable,
  input wire prwc_pkg::prwc_irq_t     irq_req,
  input wire logic                    reset_req,
  input wire logic                    reset_enable,
  // Block outputs
  input wire prwc_pkg::prwc_power_t   power,
  input wire prwc_pkg::prwc_mode_t    mode,
  input wire logic                    brownout_irq,
  input wire logic                    brownout_reset,
  input wire logic                    wake_reset
);
  import prwc_pkg::*;
  logic [11:0] wait_cnt;
  logic [7:0]  edge_cnt;
  logic        ext_q;
  int          lo;
  // Cycles and pin edges seen while the oscillator restarts
  always_ff @(posedge clk) begin
    ext_q <= ext_clk_pin;
    if (srst || !power.osc_run) begin
      wait_cnt <= 12'h000;
      edge_cnt <= 8'h00;
    end else if (!power.cpu_run) begin
      wait_cnt <= wait_cnt + 12'h001;
      edge_cnt <= edge_cnt + {7'h00, ext_clk_pin & ~ext_q};
    end
  end
  always_comb lo = (clk_src == PRWC_SRC_RC) ? RC_WAIT_CYCLES : XTAL_CYCLES;
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  chk_sleep_entry: assert property (bus.wr && bus.addr == 8'h87 && bus.wdata[1]
    |-> ##[1:3] !power.osc_run) else $error("sleep not entered");
  chk_stab_wait: assert property ($rose(power.cpu_run) && clk_src != PRWC_SRC_EXT
    |-> wait_cnt >= lo && wait_cnt <= lo + 4) else $error("bad stability wait");
  chk_ext_wait: assert property ($rose(power.cpu_run) && clk_src == PRWC_SRC_EXT
    |-> edge_cnt >= EXT_CYCLES - 1 && edge_cnt <= EXT_CYCLES + 2) else $error("bad ext wait");
  chk_irq_gate: assert property (!power.osc_run && !global_irq_enable && !reset_req
    |=> !power.osc_run) else $error("ungated irq wake");
  chk_reset_gate: assert property (!power.osc_run && !reset_enable && !global_irq_enable
    |=> !power.osc_run) else $error("ungated reset wake");
  chk_wake_fast: assert property (!power.osc_run && global_irq_enable && irq_enable.keyboard
    && irq_req.keyboard |-> ##[1:2] power.osc_run) else $error("no wake");
  chk_tpd_bod: assert property (mode == PRWC_MODE_TPD && $past(mode) == PRWC_MODE_TPD
    |-> !brownout_irq && !brownout_reset) else $error("brownout in total");
  chk_tpd_off: assert property (mode == PRWC_MODE_TPD && !power.osc_run
    |-> !power.bod_run && !power.comp_run) else $error("analog on in total");
  chk_mode_write: assert property (bus.wr && bus.addr == 8'h87
    |=> mode == $past(bus.wdata[1:0])) else $error("mode not written");
  cover property ($rose(power.cpu_run));
  cover property (brownout_irq);
  cover property (wake_reset);
endmodule // prwc_ctrl_monitor

// [verification/prwc_src_model.sv]
/*
 Wake-source model beside the core: held event levels, free external clock.
 The bench sets levels through ev; ext_clk_pin is unrelated to clk.
*/
module prwc_src_model (
  // Clock
  input  wire logic           clk,
  // Events
  output prwc_pkg::prwc_irq_t irq_req,
  output logic                reset_req,
  // External oscillator
  output logic                ext_clk_pin
);
  timeunit 1ns;
  timeprecision 1ps;
  import prwc_pkg::*;
  initial begin
    irq_req = 7'h00;
    reset_req = 1'h0;
    ext_clk_pin = 1'h0;
    #3;
    forever #14 ext_clk_pin = ~ext_clk_pin;
  end
  // Levels stand until the next call
  task automatic ev(input prwc_irq_t i, input logic r);
    @(posedge clk);
    irq_req <= i;
    reset_req <= r;
  endtask
endmodule // prwc_src_model

// [verification/power_reduction_wakeup_control_test.sv]
/*
 Bench for prwc_ctrl with the wake-source model and bound checker.
 Assumes a 125 MHz clock and srst held 16 cycles.
*/
module power_reduction_wakeup_control_test;
  timeunit 1ns;
  timeprecision 1ps;
  import prwc_pkg::*;
  logic          clk = 1'h0;
  logic          srst = 1'h1;
  prwc_bus_req_t bus = '0;
  prwc_clk_src_t clk_src = PRWC_SRC_XTAL;
  prwc_irq_t     irq_enable = 7'h7F;
  prwc_irq_t     irq_req;
  prwc_power_t   power;
  prwc_mode_t    mode;
  logic [7:0]    rdata;
  logic          global_irq_enable = 1'h0, watchdog_clock_select = 1'h0, comp_enabled = 1'h1;
  logic          reset_enable = 1'h0, brownout_cond = 1'h0, reset_req, ext_clk_pin;
  logic          brownout_irq, brownout_reset, wake_reset, double_baud_select, framing_error_select;
  int            fails = 0, n_tests = 0, cyc = 0;
  logic [7:0]    t_b5 [3] = '{8'h00, 8'h00, 8'hA0};
  logic [6:0]    t_pw [3] = '{7'h1E, 7'h3C, 7'h12};
  int            t_lo [3] = '{1024, 20, 108};
  int            t_hi [3] = '{1032, 28, 124};
  prwc_ctrl #(.RC_WAIT_CYCLES(20)) dut (.clk, .srst, .bus, .rdata, .clk_src, .ext_clk_pin,
    .global_irq_enable, .irq_enable, .watchdog_clock_select, .comp_enabled, .irq_req,
    .reset_req, .reset_enable, .brownout_cond, .power, .mode, .brownout_irq, .brownout_reset,
    .wake_reset, .double_baud_select, .framing_error_select);
  prwc_src_model src (.clk, .irq_req, .reset_req, .ext_clk_pin);
  initial forever #4 clk = ~clk;
  task automatic conclude;
    if (fails == 0 && n_tests > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic cmp(input string n, input logic [7:0] e, input logic [7:0] g);
    n_tests++;
    if (g !== e) begin
      fails++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    bus <= '{a, d, 1'h1, 1'h0};
    @(posedge clk);
    bus.wr <= 1'h0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e, input string n);
    @(posedge clk);
    bus <= '{a, 8'h00, 1'h0, 1'h1};
    @(posedge clk);
    bus.rd <= 1'h0;
    #1 cmp(n, e, rdata);
  endtask
  task automatic wait_run(output int n);
    n = 0;
    do begin
      @(posedge clk);
      #1 n++;
    end while (power.cpu_run !== 1'h1 && n < 3000);
  endtask
  task automatic t_regs;
    rd(8'h87, 8'h00, "power_control_rst");
    rd(8'hB5, 8'h00, "peripheral_power_control_rst");
    wr(8'h87, 8'hFD);
    rd(8'h87, 8'hDD, "power_control");
    cmp("flags", 8'h03, {6'h00, double_baud_select, framing_error_select});
    cmp("mode", 8'h01, {6'h00, mode});
    cmp("idle", 8'h7F, {1'h0, power});
    rd(8'h10, 8'h00, "unmapped");
    wr(8'hB5, 8'hFF);
    rd(8'hB5, 8'hEF, "peripheral_power_control");
    wr(8'hB5, 8'h00);
    wr(8'h87, 8'h00);
  endtask
  task automatic t_sleep;
    int n;
    for (int i = 0; i < 3; i++) begin
      wr(8'hB5, t_b5[i]);
      clk_src <= prwc_clk_src_t'(i[1:0]);
      global_irq_enable <= 1'h0;
      watchdog_clock_select <= (i != 1);
      comp_enabled <= (i != 2);
      wr(8'h87, 8'h02);
      repeat (4) @(posedge clk);
      #1 cmp("sleep", {1'h0, t_pw[i]}, {1'h0, power});
      src.ev(7'h40, 1'h0);
      repeat (8) @(posedge clk);
      #1 cmp("irq_gate", 8'h00, {7'h00, power.osc_run});
      @(posedge clk);
      global_irq_enable <= 1'h1;
      wait_run(n);
      cmp("wait", 8'h01, {7'h00, n >= t_lo[i] && n <= t_hi[i]});
      cmp("mode", 8'h00, {6'h00, mode});
      src.ev(7'h00, 1'h0);
    end
  endtask
  task automatic t_bod;
    brownout_cond <= 1'h1;
    wr(8'h87, 8'h10);
    repeat (2) @(posedge clk);
    #1 cmp("bod_irq", 8'h02, {6'h00, brownout_irq, brownout_reset});
    wr(8'h87, 8'h00);
    repeat (2) @(posedge clk);
    #1 cmp("bod_rst", 8'h01, {6'h00, brownout_irq, brownout_reset});
  endtask
  task automatic t_tpd;
    int n;
    watchdog_clock_select <= 1'h0;
    wr(8'h87, 8'h13);
    repeat (4) @(posedge clk);
    #1 cmp("tpd", 8'h00, {5'h00, power.bod_run, power.comp_run, brownout_irq});
    wr(8'h87, 8'h03);
    repeat (2) @(posedge clk);
    #1 cmp("tpd_rst", 8'h00, {7'h00, brownout_reset});
    src.ev(7'h13, 1'h0);
    repeat (8) @(posedge clk);
    #1 cmp("tpd_gate", 8'h00, {7'h00, power.osc_run});
    irq_enable <= 7'h77;
    src.ev(7'h08, 1'h0);
    repeat (8) @(posedge clk);
    #1 cmp("irq_mask", 8'h00, {7'h00, power.osc_run});
    irq_enable <= 7'h7F;
    wait_run(n);
    cmp("tpd_wake", 8'h01, {7'h00, n < 1100});
    brownout_cond <= 1'h0;
    src.ev(7'h00, 1'h0);
  endtask
  task automatic t_rst;
    int n;
    @(posedge clk);
    global_irq_enable <= 1'h0;
    clk_src <= PRWC_SRC_RC;
    wr(8'h87, 8'h0E);
    repeat (4) @(posedge clk);
    src.ev(7'h00, 1'h1);
    repeat (8) @(posedge clk);
    #1 cmp("rst_gate", 8'h00, {7'h00, power.osc_run});
    rd(8'hB7, 8'h01, "status_pd");
    @(posedge clk);
    reset_enable <= 1'h1;
    n = 0;
    do begin
      @(posedge clk);
      #1 n++;
    end while (wake_reset !== 1'h1 && n < 100);
    cmp("wake_rst", 8'h01, {7'h00, wake_reset});
    src.ev(7'h00, 1'h0);
    rd(8'h87, 8'h00, "power_control_clr");
    rd(8'hB5, 8'h00, "peripheral_power_control_clr");
    rd(8'hB7, 8'h08, "status_rst");
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      fails++;
      conclude;
    end
  end
  initial begin
    repeat (16) @(posedge clk);
    srst <= 1'h0;
    t_regs;
    t_sleep;
    t_bod;
    t_tpd;
    t_rst;
    conclude;
  end
endmodule // power_reduction_wakeup_control_test

bind prwc_ctrl prwc_ctrl_monitor #(.RC_WAIT_CYCLES(RC_WAIT_CYCLES), .XTAL_CYCLES(XTAL_CYCLES),
  .EXT_CYCLES(EXT_CYCLES)) mon (.clk, .srst, .bus, .clk_src, .ext_clk_pin, .global_irq_enable,
  .irq_enable, .irq_req, .reset_req, .reset_enable, .power, .mode, .brownout_irq,
  .brownout_reset, .wake_reset);
